// [src/dcrs_defines.svh]
// Constants of the drive command and reference selector: register offsets,
// reset values, field positions, limits and timing counts.
// Assumes a 100 MHz core clock and frequencies in 0.01 Hz, times in 0.1 s.
//
// Summary of operation
// - Mode bit picks V/f or vector, V/f default
// - Keypad direction bit used only from keypad
// - Reverse inhibited plus keypad reverse direction bit, with keypad as run source, shows lock
// - Run sources: keypad, terminals, communication
// - Outside three-wire, function 12 input selects alternative run source
// - Terminal schemes: two-wire dual, run+dir, three-wire
// - Scheme 0: function 0 forward, 1 reverse
// - Scheme 1: function 0 runs, 1 reverses
// - Three-wire: inputs one to three fixed roles
// - Three-wire start accepted only while stop closed
// - Reference sources coded 0 to 6
// - Combine 0: outside three-wire, function 13 picks alternative reference
// - Combine 1: reference is main plus alternative
// - Link command 0 to 650.00 Hz, used selected
// - Save setting picks keypad or link frequency
// - Keypad initial frequency: keep, zero, or setpoint
// - Zero limit and zero command: stopped, no run
// - Command above lower limit ramps from zero
// - Command at or below limit ramps from limit
// - Two ramp-up, two ramp-down times, 0.1-3600 s
// - V/f ramp scaled by span over maximum
// - Vector ramp scaled by span over rated
`ifndef DCRS_DEFINES_SVH
`define DCRS_DEFINES_SVH

// register indices on the plain register port
`define DCRS_REG_MODE        6'h00
`define DCRS_REG_DIR         6'h01
`define DCRS_REG_PRI_RUN     6'h02
`define DCRS_REG_SEC_RUN     6'h03
`define DCRS_REG_SCHEME      6'h04
`define DCRS_REG_PRI_REF     6'h05
`define DCRS_REG_SEC_REF     6'h06
`define DCRS_REG_COMBINE     6'h07
`define DCRS_REG_LINK_FREQ   6'h08
`define DCRS_REG_SAVE        6'h09
`define DCRS_REG_INIT_SEL    6'h0A
`define DCRS_REG_INIT_VAL    6'h0B
`define DCRS_REG_UPPER       6'h0C
`define DCRS_REG_LOWER       6'h0D
`define DCRS_REG_UP_ONE      6'h0E
`define DCRS_REG_DOWN_ONE    6'h0F
`define DCRS_REG_UP_TWO      6'h10
`define DCRS_REG_DOWN_TWO    6'h11
`define DCRS_REG_REV_INHIBIT 6'h12
`define DCRS_REG_FUNC_BASE   6'h13
`define DCRS_CFG_COUNT       24
`define DCRS_REG_STATUS      6'h20
`define DCRS_REG_FREQ        6'h21
`define DCRS_REG_KEY_FREQ    6'h22

// reset values of the non-zero registers
`define DCRS_RST_UPPER       16'hFDE8
`define DCRS_RST_RAMP        16'h0064
`define DCRS_RST_FUNC        16'h00FF

// status register bit positions
`define DCRS_ST_RUN          0
`define DCRS_ST_REV          1
`define DCRS_ST_LOCK         2
`define DCRS_ST_STOPPED      3
`define DCRS_ST_MODE         4
`define DCRS_ST_SRC_LO       5
`define DCRS_ST_SRC_HI       6

// terminal function codes
`define DCRS_FN_FWD_RUN      8'h00
`define DCRS_FN_REV_DIR      8'h01
`define DCRS_FN_ALT_RUN      8'h0C
`define DCRS_FN_ALT_REF      8'h0D

// value limits
`define DCRS_FREQ_MAX        16'hFDE8
`define DCRS_RAMP_MIN        16'h0001
`define DCRS_RAMP_MAX        16'h8CA0
`define DCRS_UPPER_MIN       16'h0001

// debounce timing
`define DCRS_CLK_MHZ         100
`define DCRS_DEBOUNCE_US     20
`define DCRS_DEBOUNCE_CYC    (`DCRS_DEBOUNCE_US * `DCRS_CLK_MHZ)
`define DCRS_DB_W            11

`endif

// [src/dcrs_pkg.sv]
// Types of the drive command and reference selector.
// Assumes dcrs_defines.svh supplies the widths used here.
`include "dcrs_defines.svh"

package dcrs_pkg;

   // run command source codes
   typedef enum logic [1:0] {
      DCRS_SRC_KEYPAD   = 2'h0,
      DCRS_SRC_TERMINAL = 2'h1,
      DCRS_SRC_LINK     = 2'h2
   } dcrs_src_type;

   // three-wire latch states
   typedef enum logic {
      DCRS_W3_IDLE = 1'h0,
      DCRS_W3_RUN  = 1'h1
   } dcrs_w3_type;

   // drive command bundle towards the modulator
   typedef struct packed {
      logic        run;
      logic        reverse;
      logic        lock;
      logic        stopped;
      logic        vector_mode;
      logic [1:0]  run_src;
      logic [15:0] freq_cmd;
      logic [15:0] ramp_start;
      logic [15:0] ramp_up;
      logic [15:0] ramp_down;
      logic [15:0] retained;
   } dcrs_cmd_type;

   // analog and auxiliary reference inputs
   typedef struct packed {
      logic [15:0] pot;
      logic [15:0] volt;
      logic [15:0] curr;
      logic [15:0] term_updown;
      logic [15:0] pid;
   } dcrs_refs_type;

   // all state of the selector
   typedef struct packed {
      logic [`DCRS_CFG_COUNT-1:0][15:0] cfg;
      logic [4:0]                       sync1;
      logic [4:0]                       sync2;
      logic [4:0]                       term;
      logic [4:0]                       term_q;
      logic [4:0][`DCRS_DB_W-1:0]       db_cnt;
      logic                             key_run;
      dcrs_w3_type                      w3;
      logic [15:0]                      key_freq;
      logic [15:0]                      rdata;
      dcrs_cmd_type                     cmd;
   } dcrs_state_type;

endpackage

// [src/dcrs_top.sv]
// Drive command and reference selector: run source, direction, terminal
// schemes, reference selection and limits, effective ramp times.
// Assumes synchronous user inputs, one 100 MHz clock and an outside store
// that keeps the retained frequency over power loss.
`timescale 1ns/10ps
`include "dcrs_defines.svh"

module dcrs_top (
   // clock, enable and reset
   input  wire logic                  mclk_i,
   input  wire logic                  ce_i,
   input  wire logic                  reset_n_i,
   // register port
   input  wire logic [5:0]            addr_i,
   input  wire logic [15:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic [15:0]                rdata_o,
   // terminals, keypad and link
   input  wire logic [4:0]            terminal_input_i,
   input  wire logic                  key_run_i,
   input  wire logic                  key_stop_i,
   input  wire logic                  key_up_i,
   input  wire logic                  key_down_i,
   input  wire logic                  link_run_i,
   input  wire logic                  link_rev_i,
   // reference inputs and motor figures
   input  wire dcrs_pkg::dcrs_refs_type refs_i,
   input  wire logic [15:0]           max_freq_i,
   input  wire logic [15:0]           rated_freq_i,
   input  wire logic [15:0]           min_start_freq_i,
   input  wire logic                  ramp_set_two_i,
   // drive command
   output dcrs_pkg::dcrs_cmd_type     cmd_o
);
   import dcrs_pkg::*;

   // ***************************************************************
   // reset release and state
   // ***************************************************************
   logic           rst_meta;     // first reset stage
   logic           rst_n;        // released reset for the design
   dcrs_state_type st;           // registered state
   dcrs_state_type next_st;      // next state

   // release reset through two stages so it leaves all flops together
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ***************************************************************
   // per-terminal debounce and function decode
   // ***************************************************************
   localparam logic [`DCRS_DB_W-1:0] DB_LAST = `DCRS_DB_W'(`DCRS_DEBOUNCE_CYC - 1);
   logic [4:0][`DCRS_DB_W-1:0] db_next_cnt;  // next debounce counts
   logic [4:0]                 db_next_val;  // next debounced levels
   logic [4:0]                 hit_fwd;      // function 0 active
   logic [4:0]                 hit_rev;      // function 1 active
   logic [4:0]                 hit_alt_run;  // function 12 active
   logic [4:0]                 hit_alt_ref;  // function 13 active
   logic                       three_wire;   // scheme 2 selected

   assign three_wire = (st.cfg[`DCRS_REG_SCHEME][1:0] == 2'h2);

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_term
         // debounce each terminal
         // a level must hold for the full window before it is believed
         assign db_next_cnt[gi] = (st.sync2[gi] == st.term[gi] || st.db_cnt[gi] == DB_LAST)
                                  ? '0 : st.db_cnt[gi] + `DCRS_DB_W'(1);
         assign db_next_val[gi] = (st.db_cnt[gi] == DB_LAST) ? st.sync2[gi] : st.term[gi];
         assign hit_fwd[gi]     = !three_wire && st.term[gi] &&
            (st.cfg[`DCRS_REG_FUNC_BASE + 6'(gi)][7:0] == `DCRS_FN_FWD_RUN);
         assign hit_rev[gi]     = !three_wire && st.term[gi] &&
            (st.cfg[`DCRS_REG_FUNC_BASE + 6'(gi)][7:0] == `DCRS_FN_REV_DIR);
         assign hit_alt_run[gi] = !three_wire && st.term[gi] &&
            (st.cfg[`DCRS_REG_FUNC_BASE + 6'(gi)][7:0] == `DCRS_FN_ALT_RUN);
         assign hit_alt_ref[gi] = !three_wire && st.term[gi] &&
            (st.cfg[`DCRS_REG_FUNC_BASE + 6'(gi)][7:0] == `DCRS_FN_ALT_REF);
      end
   endgenerate

   // ***************************************************************
   // helper functions
   // ***************************************************************
   // clamp written values into their legal ranges
   function automatic logic [15:0] wr_limit(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] r;
      r = d;
      unique case (a)
         `DCRS_REG_LINK_FREQ, `DCRS_REG_INIT_VAL:
            r = (d > `DCRS_FREQ_MAX) ? `DCRS_FREQ_MAX : d;
         `DCRS_REG_UPPER:
            r = (d < `DCRS_UPPER_MIN) ? `DCRS_UPPER_MIN :
                (d > `DCRS_FREQ_MAX) ? `DCRS_FREQ_MAX : d;
         `DCRS_REG_UP_ONE, `DCRS_REG_DOWN_ONE, `DCRS_REG_UP_TWO, `DCRS_REG_DOWN_TWO:
            r = (d < `DCRS_RAMP_MIN) ? `DCRS_RAMP_MIN :
                (d > `DCRS_RAMP_MAX) ? `DCRS_RAMP_MAX : d;
         default:
            r = d;
      endcase
      return r;
   endfunction

   function automatic logic [15:0] ref_pick(input logic [2:0] code, input logic [15:0] key,
                                           input logic [15:0] link, input dcrs_refs_type rf);
      logic [15:0] r;
      r = 16'h0000;
      case (code)
         3'h0:    r = key;
         3'h1:    r = rf.pot;
         3'h2:    r = rf.volt;
         3'h3:    r = rf.curr;
         3'h4:    r = rf.term_updown;
         3'h5:    r = link;
         3'h6:    r = rf.pid;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   // scale ramp by span
   // a zero base would divide by zero, so the time is then left unscaled
   function automatic logic [15:0] ramp_scale(input logic [15:0] t, input logic [15:0] span,
                                             input logic [15:0] base);
      logic [31:0] q;
      q = 32'h0000_0000;
      if (base == 16'h0000) begin
         q = {16'h0000, t};
      end else begin
         q = ({16'h0000, t} * {16'h0000, span}) / {16'h0000, base};
      end
      return (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
   endfunction

   // ***************************************************************
   // next-state logic
   // ***************************************************************
   logic         alt_run;     // alternative run source chosen
   logic         alt_ref;     // alternative reference chosen
   dcrs_src_type src;         // active run source
   logic         run_req;     // run wanted by the active source
   logic         rev_req;     // reverse wanted by the active source
   logic         inhibit;     // reverse prohibited
   logic         zero_stop;   // zero limit and zero command
   logic [16:0]  sum;         // combined reference before the clamp
   logic [15:0]  upper;       // upper limit
   logic [15:0]  lower;       // lower limit
   logic [15:0]  fcmd;        // clamped command
   logic [15:0]  span;        // command above the start frequency
   logic [15:0]  base;        // scaling base frequency
   logic [15:0]  pri_ref;     // main reference value
   logic [15:0]  sec_ref;     // alternative reference value

   always_comb begin
      next_st = st;
      upper   = st.cfg[`DCRS_REG_UPPER];
      lower   = st.cfg[`DCRS_REG_LOWER];
      inhibit = st.cfg[`DCRS_REG_REV_INHIBIT][0];

      // register writes; unmapped indices are ignored
      if (wr_i && addr_i < 6'(`DCRS_CFG_COUNT)) begin
         next_st.cfg[addr_i[4:0]] = wr_limit(addr_i, wdata_i);
      end

      // read data stand in the cycle after the strobe only
      next_st.rdata = 16'h0000;
      if (rd_i) begin
         if (addr_i < 6'(`DCRS_CFG_COUNT)) begin
            next_st.rdata = st.cfg[addr_i[4:0]];
         end else if (addr_i == `DCRS_REG_STATUS) begin
            next_st.rdata = {9'h000, st.cmd.run_src, st.cmd.vector_mode, st.cmd.stopped,
                             st.cmd.lock, st.cmd.reverse, st.cmd.run};
         end else if (addr_i == `DCRS_REG_FREQ) begin
            next_st.rdata = st.cmd.freq_cmd;
         end else if (addr_i == `DCRS_REG_KEY_FREQ) begin
            next_st.rdata = st.key_freq;
         end
      end

      next_st.sync1  = terminal_input_i;
      next_st.sync2  = st.sync1;
      next_st.db_cnt = db_next_cnt;
      next_st.term   = db_next_val;
      next_st.term_q = st.term;

      alt_run = |hit_alt_run;
      src = dcrs_src_type'(alt_run ? st.cfg[`DCRS_REG_SEC_RUN][1:0]
                                   : st.cfg[`DCRS_REG_PRI_RUN][1:0]);

      // keypad run latch; a stop key wins over a run key
      if (src != DCRS_SRC_KEYPAD || key_stop_i) begin
         next_st.key_run = 1'b0;
      end else if (key_run_i) begin
         next_st.key_run = 1'b1;
      end

      // keypad up and down steps of 0.01 Hz
      if (key_up_i && st.key_freq < `DCRS_FREQ_MAX) begin
         next_st.key_freq = st.key_freq + 16'h0001;
      end else if (key_down_i && st.key_freq != 16'h0000) begin
         next_st.key_freq = st.key_freq - 16'h0001;
      end
      // initial keypad frequency
      // loaded when a keypad run begins; code 0 keeps the present command
      if (src == DCRS_SRC_KEYPAD && key_run_i && !key_stop_i && !st.key_run) begin
         if (st.cfg[`DCRS_REG_INIT_SEL][1:0] == 2'h1) begin
            next_st.key_freq = 16'h0000;
         end else if (st.cfg[`DCRS_REG_INIT_SEL][1:0] == 2'h2) begin
            next_st.key_freq = st.cfg[`DCRS_REG_INIT_VAL];
         end
      end

      // three-wire start and stop
      // the stop contact is closed when idle, so an open contact stops
      unique case (st.w3)
         DCRS_W3_IDLE: begin
            if (src == DCRS_SRC_TERMINAL && three_wire && st.term[1] &&
                st.term[0] && !st.term_q[0]) begin
               next_st.w3 = DCRS_W3_RUN;
            end
         end
         DCRS_W3_RUN: begin
            if (src != DCRS_SRC_TERMINAL || !three_wire || !st.term[1]) begin
               next_st.w3 = DCRS_W3_IDLE;
            end
         end
      endcase

      // run and direction per source
      run_req = 1'b0;
      rev_req = 1'b0;
      unique case (src)
         DCRS_SRC_KEYPAD: begin
            run_req = st.key_run;
            rev_req = st.cfg[`DCRS_REG_DIR][0];
         end
         DCRS_SRC_TERMINAL: begin
            if (st.cfg[`DCRS_REG_SCHEME][1:0] == 2'h0) begin
               // forward and reverse switches
               // both closed counts as a stop
               run_req = (|hit_fwd) ^ (|hit_rev);
               rev_req = (|hit_rev) && !(|hit_fwd);
            end else if (st.cfg[`DCRS_REG_SCHEME][1:0] == 2'h1) begin
               run_req = |hit_fwd;
               rev_req = |hit_rev;
            end else if (three_wire) begin
               run_req = (st.w3 == DCRS_W3_RUN);
               rev_req = st.term[2];
            end
         end
         DCRS_SRC_LINK: begin
            run_req = link_run_i;
            rev_req = link_rev_i;
         end
         default: begin
            run_req = 1'b0;
            rev_req = 1'b0;
         end
      endcase

      alt_ref = |hit_alt_ref;
      pri_ref = ref_pick(st.cfg[`DCRS_REG_PRI_REF][2:0], st.key_freq,
                         st.cfg[`DCRS_REG_LINK_FREQ], refs_i);
      sec_ref = ref_pick(st.cfg[`DCRS_REG_SEC_REF][2:0], st.key_freq,
                         st.cfg[`DCRS_REG_LINK_FREQ], refs_i);
      if (st.cfg[`DCRS_REG_COMBINE][0]) begin
         sum = {1'b0, pri_ref} + {1'b0, sec_ref};
      end else begin
         sum = {1'b0, alt_ref ? sec_ref : pri_ref};
      end
      fcmd = (sum > {1'b0, upper}) ? upper : sum[15:0];

      zero_stop = (lower == 16'h0000) && (fcmd == 16'h0000);

      next_st.cmd.vector_mode = st.cfg[`DCRS_REG_MODE][0];
      next_st.cmd.run_src     = src;
      next_st.cmd.run         = run_req && !zero_stop;
      next_st.cmd.stopped     = run_req && zero_stop;
      next_st.cmd.lock        = inhibit && src == DCRS_SRC_KEYPAD && st.cfg[`DCRS_REG_DIR][0];
      next_st.cmd.reverse     = rev_req && !inhibit;
      next_st.cmd.freq_cmd    = fcmd;
      next_st.cmd.ramp_start  = (lower != 16'h0000 && fcmd <= lower) ? lower : 16'h0000;

      base = st.cfg[`DCRS_REG_MODE][0] ? rated_freq_i : max_freq_i;
      span = (fcmd > min_start_freq_i) ? fcmd - min_start_freq_i : 16'h0000;
      next_st.cmd.ramp_up   = ramp_scale(ramp_set_two_i ? st.cfg[`DCRS_REG_UP_TWO]
                                         : st.cfg[`DCRS_REG_UP_ONE], span, base);
      next_st.cmd.ramp_down = ramp_scale(ramp_set_two_i ? st.cfg[`DCRS_REG_DOWN_TWO]
                                         : st.cfg[`DCRS_REG_DOWN_ONE], span, base);
      next_st.cmd.retained  = st.cfg[`DCRS_REG_SAVE][0] ? st.cfg[`DCRS_REG_LINK_FREQ]
                                                        : st.key_freq;
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   // clock enable low freezes every field
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st                             <= '0;
         st.cfg[`DCRS_REG_UPPER]        <= `DCRS_RST_UPPER;
         st.cfg[`DCRS_REG_UP_ONE]       <= `DCRS_RST_RAMP;
         st.cfg[`DCRS_REG_DOWN_ONE]     <= `DCRS_RST_RAMP;
         st.cfg[`DCRS_REG_UP_TWO]       <= `DCRS_RST_RAMP;
         st.cfg[`DCRS_REG_DOWN_TWO]     <= `DCRS_RST_RAMP;
         st.cfg[`DCRS_REG_FUNC_BASE]    <= `DCRS_RST_FUNC;
         st.cfg[`DCRS_REG_FUNC_BASE+1]  <= `DCRS_RST_FUNC;
         st.cfg[`DCRS_REG_FUNC_BASE+2]  <= `DCRS_RST_FUNC;
         st.cfg[`DCRS_REG_FUNC_BASE+3]  <= `DCRS_RST_FUNC;
         st.cfg[`DCRS_REG_FUNC_BASE+4]  <= `DCRS_RST_FUNC;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign cmd_o   = st.cmd;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   AST_MODE_WRITE: assert property (
      (ce_i && wr_i && addr_i == `DCRS_REG_MODE) ##1 ce_i |=>
         cmd_o.vector_mode == $past(wdata_i[0], 2))
      else $error("control mode does not follow written value");

   AST_LOCK: assert property (
      cmd_o.lock |-> cmd_o.run_src == DCRS_SRC_KEYPAD && !cmd_o.reverse)
      else $error("lock shown while reversing or off keypad");

   AST_CLAMP: assert property (
      cmd_o.freq_cmd <= st.cfg[`DCRS_REG_UPPER] || $changed(st.cfg[`DCRS_REG_UPPER]))
      else $error("command above upper limit");

   AST_STOPPED: assert property (
      cmd_o.stopped |-> !cmd_o.run && cmd_o.freq_cmd == 16'h0000)
      else $error("stopped shown with output running");

   AST_START_ZERO: assert property (
      cmd_o.freq_cmd > st.cfg[`DCRS_REG_LOWER] && $stable(st.cfg[`DCRS_REG_LOWER])
         |-> cmd_o.ramp_start == 16'h0000)
      else $error("ramp does not start at zero");

   AST_START_LOWER: assert property (
      $stable(st.cfg[`DCRS_REG_LOWER]) && st.cfg[`DCRS_REG_LOWER] != 16'h0000 &&
      cmd_o.freq_cmd <= st.cfg[`DCRS_REG_LOWER] |-> cmd_o.ramp_start == st.cfg[`DCRS_REG_LOWER])
      else $error("ramp does not start at lower limit");

   AST_LINK_RANGE: assert property (
      st.cfg[`DCRS_REG_LINK_FREQ] <= `DCRS_FREQ_MAX && st.cfg[`DCRS_REG_INIT_VAL] <= `DCRS_FREQ_MAX)
      else $error("link or initial frequency beyond range");

   AST_W3_STOP: assert property (
      ce_i && !st.term[1] |=> st.w3 == DCRS_W3_IDLE)
      else $error("three-wire run kept with stop contact open");

   AST_READ_ONCE: assert property (
      ce_i && !rd_i |=> rdata_o == 16'h0000)
      else $error("read data stand without a read strobe");

   AST_RAMP_RANGE: assert property (
      st.cfg[`DCRS_REG_UP_ONE] >= `DCRS_RAMP_MIN && st.cfg[`DCRS_REG_UP_ONE] <= `DCRS_RAMP_MAX)
      else $error("ramp time outside range");

endmodule

// [tb/dcrs_operator.sv]
// Operator panel model: the maintained switches and push buttons on the terminals.
// Assumes the bench sets switch positions; contacts change just after a clock edge.
`timescale 1ns/10ps

module dcrs_operator (
   // clock
   input  wire logic       mclk_i,
   // switch positions wanted, high = closed
   input  wire logic [4:0] sw_i,
   // contacts seen by the drive
   output logic [4:0]      terminal_input_o
);
   // contacts held
   // contacts stay as set until the bench moves them, like maintained switches or a held NC stop
   initial terminal_input_o = 5'h00;
   always @(posedge mclk_i) terminal_input_o <= sw_i;
endmodule

// [tb/test_dcrs_top.sv]
// Bench for the command and reference selector; register port plus operator model.
// Assumes the 2000-cycle terminal debounce of the design.
`timescale 1ns/10ps

module test_dcrs_top;
   import dcrs_pkg::*;
   logic mclk_i = 0, reset_n_i = 0, ce = 1, wr_i = 0, rd_i = 0, kr = 0, ks = 0, lk = 0;
   logic [5:0] addr_i = 6'h00;
   logic [15:0] wdata_i = 16'h0000, fq = 16'h0000, rdata_o;
   logic [15:0] mx = 16'h1388, rt = 16'h09C4;
   logic ln = 0, r2 = 0;
   logic [4:0] sw = 5'h00, term;
   dcrs_refs_type refs_i = '0;
   dcrs_cmd_type cmd_o;
   int fail_count = 0, total_checks = 0;
   always #5 mclk_i = ~mclk_i;
   dcrs_operator op (.mclk_i(mclk_i), .sw_i(sw), .terminal_input_o(term));
   dcrs_top uut (.mclk_i(mclk_i), .ce_i(ce), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .terminal_input_i(term), .key_run_i(kr), .key_stop_i(ks), .key_up_i(lk),
      .key_down_i(lk), .link_run_i(ln), .link_rev_i(lk), .refs_i(refs_i),
      .max_freq_i(mx), .rated_freq_i(rt), .min_start_freq_i(fq),
      .ramp_set_two_i(r2), .cmd_o(cmd_o));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [15:0] e);
      @(posedge mclk_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   task settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task t_regs;
      rd(6'h0C, 16'hFDE8);
      rd(6'h0E, 16'h0064);
      rd(6'h3F, 16'h0000);
      wr(6'h00, 16'h0001);
      settle(2); chk(cmd_o.vector_mode, 1);
      wr(6'h00, 16'h0000);
      ce <= 1'b0; wr(6'h00, 16'h0001); ce <= 1'b1;
      settle(2); chk(cmd_o.vector_mode, 0);
      $display("registers done");
   endtask
   task t_key;
      wr(6'h01, 16'h0001); wr(6'h12, 16'h0001);
      @(posedge mclk_i) kr <= 1'b1;
      @(posedge mclk_i) kr <= 1'b0;
      settle(3); chk(cmd_o.stopped, 1);
      chk(cmd_o.run, 0);
      chk(cmd_o.lock, 1);
      chk(cmd_o.reverse, 0);
      @(posedge mclk_i) ks <= 1'b1;
      @(posedge mclk_i) ks <= 1'b0;
      wr(6'h0A, 16'h0002); wr(6'h0B, 16'h1388);
      @(posedge mclk_i) kr <= 1'b1;
      @(posedge mclk_i) kr <= 1'b0;
      settle(3); chk(cmd_o.run, 1);
      chk(cmd_o.freq_cmd, 16'h1388);
      @(posedge mclk_i) ks <= 1'b1;
      @(posedge mclk_i) ks <= 1'b0;
      settle(3); chk(cmd_o.run, 0);
      wr(6'h12, 16'h0000);
      $display("keypad done");
   endtask
   task t_term;
      wr(6'h02, 16'h0001); wr(6'h13, 16'h0000); wr(6'h14, 16'h0001);
      sw <= 5'h02; settle(2010);
      chk(cmd_o.run, 1); chk(cmd_o.reverse, 1);
      chk(cmd_o.run_src, 1);
      wr(6'h04, 16'h0001); sw <= 5'h03; settle(2010);
      chk(cmd_o.run, 1); chk(cmd_o.reverse, 1);
      sw <= 5'h00; settle(2010); chk(cmd_o.run, 0);
      wr(6'h03, 16'h0002); wr(6'h15, 16'h000C); ln <= 1'b1; sw <= 5'h04; settle(2010);
      chk(cmd_o.run_src, 2);
      chk(cmd_o.run, 1);
      wr(6'h04, 16'h0002); sw <= 5'h01; settle(2010);
      chk(cmd_o.run, 0);
      sw <= 5'h06; settle(2010);
      sw <= 5'h07; settle(2010);
      chk(cmd_o.run, 1);
      chk(cmd_o.reverse, 1);
      chk(cmd_o.run_src, 1);
      sw <= 5'h04; settle(2010);
      chk(cmd_o.run, 0);
      $display("terminals done");
   endtask
   task t_ref;
      wr(6'h05, 16'h0002); wr(6'h06, 16'h0003); wr(6'h07, 16'h0001);
      refs_i.volt <= 16'h03E8; refs_i.curr <= 16'h07D0;
      settle(4); chk(cmd_o.freq_cmd, 16'h0BB8);
      wr(6'h0C, 16'h09C4);
      settle(4); chk(cmd_o.freq_cmd, 16'h09C4);
      chk(cmd_o.ramp_up, 16'h0032);
      chk(cmd_o.ramp_start, 16'h0000);
      chk(cmd_o.retained, 16'h1388);
      wr(6'h00, 16'h0001); wr(6'h0D, 16'h0BB8); wr(6'h11, 16'h00C8); r2 <= 1'b1;
      settle(4); chk(cmd_o.ramp_up, 16'h0064);
      chk(cmd_o.ramp_down, 16'h00C8);
      chk(cmd_o.ramp_start, 16'h0BB8);
      wr(6'h08, 16'hFFFF); wr(6'h09, 16'h0001);
      rd(6'h08, 16'hFDE8);
      settle(2); chk(cmd_o.retained, 16'hFDE8);
      $display("reference done");
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_regs; t_key; t_term; t_ref;
      tally_and_finish;
   end
   initial begin
      #300000;
      fail_count++;
      tally_and_finish;
   end
endmodule
